// [design/bob_exec.sv]
// decode and execution of bit test/skip, bit toggle and two relative branches
// assumes the fetch unit offers one instruction word per cycle at Q1 and a
// data memory that returns read data in the cycle after the read strobe
//
// The register addresses and the plain strobed port are this design's own decisions.
`default_nettype none

// Behaviour
// - upper nibble 1011 tests a bit and skips the next instruction when clear.
// - on a skip the already fetched instruction is discarded and a no-op runs.
// - skip test takes one cycle, two when skipping, three over two-word code.
// - access bit 0 picks the access bank, 1 picks the bank register.
// - upper nibble 0111 decodes as toggle with bit index, access bit, address.
// - toggle inverts one bit of the byte, read-process-write in one cycle.
// - upper byte 1110 0100 decodes as branch on overflow with 8-bit offset.
// - branch on overflow jumps only with overflow set, else falls through.
// - taken branch offset is signed -128..127, doubled and added.
// - branch target equals own address plus two plus twice the offset.
// - upper byte 1110 0000 decodes as branch on zero with 8-bit offset.
// - branch on zero jumps only with zero flag set, else falls through.
module bob_exec
  import bob_pkg::*;
#(
  parameter int         ADDR_PC_W = PC_W,
  parameter logic [3:0] ACC_BANK  = ACCESS_BANK
)
(
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     arst_n,
  // instruction from fetch
  input  wire logic [WORD_W-1:0]        instr_word,
  input  wire logic                     instr_valid,
  input  wire logic [ADDR_PC_W-1:0]     instr_pc,
  input  wire logic                     next_two_word,
  // core state
  input  wire logic                     flag_ov,
  input  wire logic                     flag_z,
  input  wire logic [BANK_W-1:0]        bsr,
  // data memory
  input  wire logic [BYTE_W-1:0]        dm_rdata,
  output var  logic [BANK_W+BYTE_W-1:0] dm_addr,
  output var  logic                     dm_rd,
  output var  logic                     dm_wr,
  output var  logic [BYTE_W-1:0]        dm_wdata,
  // program counter
  output var  logic                     pc_wr,
  output var  logic [ADDR_PC_W-1:0]     pc_wdata,
  // cycle status
  output var  bob_phase_t               q_phase,
  output var  logic                     cyc_end,
  output var  logic                     nop_cycle,
  output var  logic                     flags_hold
);

  // ************************************************************
  // elaboration checks and helpers
  // ************************************************************
  // refused at elaboration: the sign extension below needs at least ten bits
  if (ADDR_PC_W < 10)
  begin : g_pc_w_chk
    $error("bob_exec: program counter too narrow for a doubled offset");
  end

  // one-hot mask for a 3-bit bit index
  function automatic logic [BYTE_W-1:0] bob_mask(input logic [2:0] idx);
    logic [BYTE_W-1:0] m;
    m = BYTE_RST;
    m[idx] = 1'b1;
    return m;
  endfunction

  // classify an instruction word of this group
  function automatic bob_op_t bob_decode(input logic [WORD_W-1:0] w);
    bob_op_t op;
    op = OP_NONE;
    if (w[NIB_LSB +: 4] == OPC_SKIP_CLR)
    begin
      op = OP_SKIP;
    end
    else if (w[NIB_LSB +: 4] == OPC_TOGGLE)
    begin
      op = OP_TOGGLE;
    end
    else if (w[BYTE_LSB +: 8] == OPC_BR_OV)
    begin
      op = OP_BR_OV;
    end
    else if (w[BYTE_LSB +: 8] == OPC_BR_ZERO)
    begin
      op = OP_BR_Z;
    end
    return op;
  endfunction

  // ************************************************************
  // phase generator
  // ************************************************************
  bob_qphase #(
    .NPH (NUM_PHASES)
  ) u_qphase (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .q_phase  (q_phase),
    .cyc_end  (cyc_end)
  );

  // ************************************************************
  // decode at Q1
  // ************************************************************
  bob_state_t             st_r;
  bob_op_t                op_r;
  bob_op_t                dec_nxt;
  logic [2:0]             bit_r;
  logic [7:0]             off_r;
  logic [ADDR_PC_W-1:0]   pc_r;
  logic                   skip_r;
  logic                   two_r;
  logic [1:0]             nop_left_r;
  logic                   taken_nxt;
  logic [ADDR_PC_W-1:0]   target_nxt;
  logic                   take_q1;

  // a fetched word is only taken in a normal cycle; in a no-op cycle it is
  // the discarded one, so it must never reach the decoder
  assign take_q1 = (q_phase == PH_Q1) && (st_r == ST_RUN) && instr_valid;
  assign dec_nxt = bob_decode(instr_word);

  // latch the fields of the instruction being executed
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      op_r  <= OP_NONE;
      bit_r <= 3'h0;
      off_r <= BYTE_RST;
      pc_r  <= '0;
    end
    else if (q_phase == PH_Q1)
    begin
      op_r  <= take_q1 ? dec_nxt : OP_NONE;
      bit_r <= instr_word[BIT_IDX_LSB +: 3];
      off_r <= instr_word[FADDR_LSB +: 8];
      pc_r  <= instr_pc;
    end
  end

  // ************************************************************
  // data memory read in Q2
  // ************************************************************
  // address is set up with the strobe so the bank cannot change under it
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dm_rd   <= 1'b0;
      dm_addr <= '0;
    end
    else
    begin
      dm_rd <= take_q1 && ((dec_nxt == OP_SKIP) || (dec_nxt == OP_TOGGLE));
      if (take_q1)
      begin
        dm_addr <= {(instr_word[ACC_BIT_POS] ? bsr : ACC_BANK),
                    instr_word[FADDR_LSB +: 8]};
      end
    end
  end

  // ************************************************************
  // process in Q3: bit test, toggle data, branch condition
  // ************************************************************
  // the offset is sign extended and doubled before the add
  assign target_nxt = ADDR_PC_W'(pc_r + ADDR_PC_W'(PC_STEP)
                      + {{(ADDR_PC_W-9){off_r[7]}}, off_r, 1'b0});
  assign taken_nxt  = ((op_r == OP_BR_OV) && flag_ov)
                   || ((op_r == OP_BR_Z) && flag_z);

  // write strobes stand for the Q4 cycle only
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dm_wr    <= 1'b0;
      dm_wdata <= BYTE_RST;
      pc_wr    <= 1'b0;
      pc_wdata <= '0;
      skip_r   <= 1'b0;
      two_r    <= 1'b0;
    end
    else if (q_phase == PH_Q3)
    begin
      dm_wr    <= (op_r == OP_TOGGLE);
      dm_wdata <= dm_rdata ^ bob_mask(bit_r);
      pc_wr    <= taken_nxt;
      pc_wdata <= target_nxt;
      skip_r   <= (op_r == OP_SKIP) && !dm_rdata[bit_r];
      two_r    <= next_two_word;
    end
    else
    begin
      dm_wr <= 1'b0;
      pc_wr <= 1'b0;
    end
  end

  // ************************************************************
  // forced no-op cycles after a skip or a taken branch
  // ************************************************************
  // a skip over a two-word instruction needs both words thrown away
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r       <= ST_RUN;
      nop_left_r <= 2'h0;
      nop_cycle  <= 1'b0;
    end
    else if (q_phase == PH_Q4)
    begin
      unique case (st_r)
        ST_RUN:
        begin
          if (skip_r)
          begin
            st_r       <= ST_NOP;
            nop_left_r <= two_r ? NOPS_TWO : NOPS_ONE;
            nop_cycle  <= 1'b1;
          end
          else if (pc_wr)
          begin
            st_r       <= ST_NOP;
            nop_left_r <= NOPS_ONE;
            nop_cycle  <= 1'b1;
          end
        end
        ST_NOP:
        begin
          nop_left_r <= 2'(nop_left_r - 2'h1);
          if (nop_left_r == NOPS_ONE)
          begin
            st_r      <= ST_RUN;
            nop_cycle <= 1'b0;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // status flag protection
  // ************************************************************
  // the flag logic holds its flags while this is high from Q2 to Q4
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flags_hold <= 1'b0;
    end
    else if (q_phase == PH_Q1)
    begin
      flags_hold <= take_q1 && (dec_nxt != OP_NONE);
    end
    else if (q_phase == PH_Q4)
    begin
      flags_hold <= 1'b0;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic skip_go;
  logic br_idle;
  assign skip_go = (q_phase == PH_Q4) && (st_r == ST_RUN) && skip_r;
  assign br_idle = (q_phase == PH_Q3) && ((op_r == OP_BR_OV) || (op_r == OP_BR_Z))
                   && !taken_nxt;

  skip_one_nop_a: assert property (skip_go && !two_r |=> nop_cycle[*4] ##1 !nop_cycle)
    else $error("skip did not give exactly one no-op cycle");
  skip_two_nop_a: assert property (skip_go && two_r |=> nop_cycle[*8] ##1 !nop_cycle)
    else $error("skip over two-word code did not give two no-op cycles");
  no_skip_a: assert property ((q_phase == PH_Q4) && (op_r == OP_SKIP) && !skip_r
                              |=> !nop_cycle)
    else $error("skip test with bit set caused a no-op cycle");
  bank_select_a: assert property (dm_rd |-> dm_addr == {
                                  ($past(instr_word[ACC_BIT_POS]) ? $past(bsr) : ACC_BANK),
                                  $past(instr_word[7:0])})
    else $error("data address bank does not follow the access bit");
  toggle_one_bit_a: assert property (dm_wr |-> (q_phase == PH_Q4)
                                     && ($countones(dm_wdata ^ $past(dm_rdata)) == 1))
    else $error("toggle write differs from read by other than one bit");
  read_in_q2_a: assert property (dm_rd |-> q_phase == PH_Q2 ##2 dm_wr == (op_r == OP_TOGGLE))
    else $error("read strobe out of phase or toggle write missing");
  branch_target_a: assert property (pc_wr |-> pc_wdata == ADDR_PC_W'(pc_r + ADDR_PC_W'(2)
                                    + ADDR_PC_W'(signed'(off_r)) * 2))
    else $error("branch target is not address plus two plus twice offset");
  branch_idle_a: assert property (br_idle |=> !pc_wr ##1 !nop_cycle)
    else $error("branch not taken wrote the program counter");
  flags_held_a: assert property (take_q1 && (dec_nxt != OP_NONE) |=> flags_hold[*3])
    else $error("status flags not held during a group instruction");

  // branch outcome follows the flag seen in the process phase
  ov_branch_a: assert property ((q_phase == PH_Q3) && (op_r == OP_BR_OV)
                                |=> pc_wr == $past(flag_ov))
    else $error("branch on overflow ignored the overflow flag");
  zero_branch_a: assert property ((q_phase == PH_Q3) && (op_r == OP_BR_Z)
                                  |=> pc_wr == $past(flag_z))
    else $error("branch on zero ignored the zero flag");
  // a taken branch writes the counter in the last phase only, then runs one no-op
  pc_wr_phase_a: assert property (pc_wr |-> (q_phase == PH_Q4)
                                  && ((op_r == OP_BR_OV) || (op_r == OP_BR_Z)))
    else $error("program counter written outside the last phase of a branch");
  taken_nop_a: assert property (pc_wr |=> nop_cycle[*4] ##1 !nop_cycle)
    else $error("taken branch did not give exactly one no-op cycle");
  // the word fetched during a forced no-op must never start a memory access
  nop_discard_a: assert property ((q_phase == PH_Q1) && nop_cycle
                                  |=> !dm_rd && !flags_hold)
    else $error("word offered in a no-op cycle was decoded");
  // a longer strobe would write the toggled byte twice
  toggle_pulse_a: assert property (dm_wr |=> !dm_wr)
    else $error("toggle write strobe longer than one cycle");
  // words outside the group must leave memory, counter and flags alone
  outside_quiet_a: assert property (take_q1
                                    && (instr_word[NIB_LSB +: 4] != OPC_SKIP_CLR)
                                    && (instr_word[NIB_LSB +: 4] != OPC_TOGGLE)
                                    && (instr_word[BYTE_LSB +: 8] != OPC_BR_OV)
                                    && (instr_word[BYTE_LSB +: 8] != OPC_BR_ZERO)
                                    |=> !dm_rd && !flags_hold ##2 !dm_wr && !pc_wr)
    else $error("word outside the group caused activity");
  // flag logic is free again from the next decode phase on
  hold_clear_a: assert property ((q_phase == PH_Q4) |=> !flags_hold)
    else $error("flag hold still high after the last phase");

  skip_taken_c: cover property (skip_go && !two_r);
  skip_two_c:   cover property (skip_go && two_r);
  toggle_c:     cover property (dm_wr);
  branch_c:     cover property (pc_wr ##1 nop_cycle);
  branch_idle_c: cover property (br_idle);

endmodule // bob_exec

`default_nettype wire

// [design/bob_qphase.sv]
// phase generator: splits the core clock into four instruction phases
// assumes one free-running core clock and an asynchronous active-low reset
`default_nettype none

module bob_qphase
  import bob_pkg::*;
#(
  parameter int NPH = NUM_PHASES
)
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // phase outputs
  output var  bob_phase_t q_phase,
  output var  logic       cyc_end
);

  // ************************************************************
  // phase counter
  // ************************************************************
  // the two-bit phase code only wraps correctly for four phases
  if (NPH != 4)
  begin : g_nph_chk
    $error("bob_qphase: only a four-phase cycle is supported");
  end

  // counts Q1..Q4 and wraps; cyc_end marks the Q3 cycle so it is high in Q4
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q_phase <= PH_Q1;
      cyc_end <= 1'b0;
    end
    else
    begin
      q_phase <= bob_phase_t'(q_phase + 2'h1);
      cyc_end <= (q_phase == PH_Q3);
    end
  end

endmodule // bob_qphase

`default_nettype wire

// [pkg/bob_pkg.sv]
// constants and types shared by the bit-op and branch decode block
// assumes a four-phase instruction cycle made of core clock cycles
`default_nettype none

package bob_pkg;

  // ************************************************************
  // instruction encodings and field positions
  // ************************************************************
  localparam logic [3:0] OPC_SKIP_CLR  = 4'hB;   // bit test, skip if clear
  localparam logic [3:0] OPC_TOGGLE    = 4'h7;   // bit toggle
  localparam logic [7:0] OPC_BR_OV     = 8'hE4;  // branch on overflow
  localparam logic [7:0] OPC_BR_ZERO   = 8'hE0;  // branch on zero
  localparam int         NIB_LSB       = 12;     // upper nibble position
  localparam int         BYTE_LSB      = 8;      // upper byte position
  localparam int         BIT_IDX_LSB   = 9;      // 3-bit bit index
  localparam int         ACC_BIT_POS   = 8;      // access bit
  localparam int         FADDR_LSB     = 0;      // 8-bit file address / offset

  // ************************************************************
  // sizes, reset values and cycle counts
  // ************************************************************
  localparam int         WORD_W        = 16;
  localparam int         BYTE_W        = 8;
  localparam int         BANK_W        = 4;
  localparam int         PC_W          = 21;
  localparam int         NUM_PHASES    = 4;
  localparam logic [3:0] ACCESS_BANK   = 4'h0;   // bank used when access bit is 0
  localparam logic [7:0] BYTE_RST      = 8'h00;
  localparam logic [1:0] NOPS_ONE      = 2'h1;   // one forced no-op cycle
  localparam logic [1:0] NOPS_TWO      = 2'h2;   // skip over a two-word instruction
  localparam int         PC_STEP       = 2;      // bytes per instruction word

  // ************************************************************
  // phases, operations and states
  // ************************************************************
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } bob_phase_t;

  typedef enum logic [2:0] {
    OP_NONE   = 3'b000,
    OP_SKIP   = 3'b001,
    OP_TOGGLE = 3'b010,
    OP_BR_OV  = 3'b011,
    OP_BR_Z   = 3'b100
  } bob_op_t;

  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_NOP = 1'b1
  } bob_state_t;

endpackage : bob_pkg

`default_nettype wire

// [verification/bob_dmem_model.sv]
// data memory model standing on the far side of the decode block
// assumes one core clock; the bench may preload or peek at mem directly
`default_nettype none

module bob_dmem_model
  import bob_pkg::*;
(
  // clock
  input  wire logic                     core_clk,
  // memory port
  input  wire logic [BANK_W+BYTE_W-1:0] dm_addr,
  input  wire logic                     dm_rd,
  input  wire logic                     dm_wr,
  input  wire logic [BYTE_W-1:0]        dm_wdata,
  output var  logic [BYTE_W-1:0]        dm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [BYTE_W-1:0] mem [0:4095];

  initial dm_rdata = BYTE_RST;

  // read data stand one cycle only; at other times the bus flips so a
  // sample taken one cycle late sees the inverted byte and cannot look right
  always @(posedge core_clk)
  begin
    if (dm_rd)
      dm_rdata <= mem[dm_addr];
    else
      dm_rdata <= ~dm_rdata;
    if (dm_wr)
      mem[dm_addr] <= dm_wdata;
  end
endmodule // bob_dmem_model

`default_nettype wire

// [verification/bob_exec_tb.sv]
// self-checking bench for the bit-op and branch decode block
// assumes bob_exec with default parameters and the data memory model
`default_nettype none

module bob_exec_tb
  import bob_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk, arst_n, instr_valid, next_two_word, flag_ov, flag_z;
  logic [15:0] instr_word;
  logic [20:0] instr_pc, pc_wdata, p_data;
  logic [3:0]  bsr;
  logic [7:0]  dm_rdata, dm_wdata, w_data;
  logic [11:0] dm_addr, a_seen;
  logic        dm_rd, dm_wr, pc_wr, cyc_end, nop_cycle, flags_hold;
  bob_phase_t  q_phase;
  logic [7:0]  n_rd, n_wr, n_pc, n_nop, n_fh, n_ce;
  int          fail_count, samples_checked;

  bob_exec dut (.core_clk(core_clk), .arst_n(arst_n), .instr_word(instr_word),
    .instr_valid(instr_valid), .instr_pc(instr_pc), .next_two_word(next_two_word),
    .flag_ov(flag_ov), .flag_z(flag_z), .bsr(bsr), .dm_rdata(dm_rdata),
    .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata),
    .pc_wr(pc_wr), .pc_wdata(pc_wdata), .q_phase(q_phase), .cyc_end(cyc_end),
    .nop_cycle(nop_cycle), .flags_hold(flags_hold));

  bob_dmem_model u_mem (.core_clk(core_clk), .dm_addr(dm_addr), .dm_rd(dm_rd),
    .dm_wr(dm_wr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));

  // ************************************************************
  // clock, watchdog, shared tasks
  // ************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // the whole run needs about 760 cycles; far beyond that means a hang
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    end_of_test;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // offer one word in Q1, then tally what the block does for 12 cycles
  task automatic run(input logic [15:0] w, input logic [20:0] pc, input logic ov,
                     input logic z, input logic ntw, input logic [3:0] bk);
    int i;
    i = 0;
    {n_rd, n_wr, n_pc, n_nop, n_fh, n_ce} = '0;
    p_data = '0;
    @(negedge core_clk);
    while (q_phase !== PH_Q4 && i < 16)
    begin
      @(negedge core_clk);
      i++;
    end
    @(posedge core_clk);
    instr_word <= w;
    instr_pc <= pc;
    instr_valid <= 1'b1;
    flag_ov <= ov;
    flag_z <= z;
    next_two_word <= ntw;
    bsr <= bk;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    for (i = 1; i <= 12; i++)
    begin
      @(negedge core_clk);
      n_rd += dm_rd;
      n_wr += dm_wr;
      n_pc += pc_wr;
      n_nop += nop_cycle;
      n_ce += cyc_end;
      if (i <= 3)
        n_fh += flags_hold;
      if (i == 1)
        a_seen = dm_addr;
      if (dm_wr)
        w_data = dm_wdata;
      if (pc_wr)
        p_data = pc_wdata;
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  // every bit with both access modes; bank 5 differs from the access bank
  task automatic t_toggle;
    logic [11:0] ad;
    for (int b = 0; b < 8; b++)
      for (int a = 0; a < 2; a++)
      begin
        ad = {(a == 1) ? 4'h5 : ACCESS_BANK, 8'hF8 + b[7:0]};
        u_mem.mem[ad] = 8'h75;
        run({OPC_TOGGLE, b[2:0], a[0], ad[7:0]}, 21'h100, 1'b0, 1'b0, 1'b0, 4'h5);
        chk(a_seen, ad);
        chk(n_wr, 1);
        chk(u_mem.mem[ad], 8'h75 ^ (8'h01 << b));
        chk(n_nop, 0);
        chk(n_fh, 3);
      end
    $display("toggle test done");
  endtask

  // bit set and clear, followed by one- and two-word code
  task automatic t_skip;
    logic [11:0] ad;
    for (int c = 0; c < 4; c++)
    begin
      ad = {4'hA, 8'h20};
      u_mem.mem[ad] = c[0] ? 8'h80 : 8'h7F;
      run({OPC_SKIP_CLR, 3'h7, 1'b1, 8'h20}, 21'h200, 1'b0, 1'b0, c[1], 4'hA);
      chk(a_seen, ad);
      chk({n_rd, n_wr}, 16'h0100);
      chk(n_nop, c[0] ? 0 : (c[1] ? 8 : 4));
      chk(n_fh, 3);
    end
    $display("skip test done");
  endtask

  // both branches, all flag pairs, offsets at the ends of the range
  task automatic t_branch;
    logic [7:0] offs [3] = '{8'h80, 8'h7F, 8'hFF};
    logic taken;
    for (int k = 0; k < 2; k++)
      for (int f = 0; f < 4; f++)
        for (int o = 0; o < 3; o++)
        begin
          taken = (k == 0) ? f[0] : f[1];
          run({(k == 0) ? OPC_BR_OV : OPC_BR_ZERO, offs[o]}, 21'h1000, f[0], f[1],
              1'b0, 4'h0);
          chk(n_pc, taken);
          chk(n_nop, taken ? 4 : 0);
          chk(p_data, taken ? 21'(21'h1002 + {{12{offs[o][7]}}, offs[o], 1'b0}) : 0);
          chk({n_rd, n_wr, n_fh}, 24'h000003);
        end
    $display("branch test done");
  endtask

  // words outside the group leave the strobes, no-op and flag hold quiet
  task automatic t_other;
    logic [15:0] ws [3] = '{16'h6B00, 16'hE100, 16'hE500};
    for (int i = 0; i < 3; i++)
    begin
      run(ws[i], 21'h300, 1'b1, 1'b1, 1'b0, 4'h5);
      chk({n_rd, n_wr, n_pc, n_nop, n_fh}, 0);
      chk(n_ce, 3);
    end
    $display("outside group test done");
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    fail_count = 0;
    samples_checked = 0;
    arst_n = 1'b0;
    {instr_valid, next_two_word, flag_ov, flag_z} = 4'h0;
    instr_word = 16'h0000;
    instr_pc = 21'h000000;
    bsr = 4'h0;
    repeat (8) @(posedge core_clk);
    chk({q_phase, dm_rd, dm_wr, pc_wr, nop_cycle, flags_hold}, 0);
    arst_n <= 1'b1;
    t_toggle;
    t_skip;
    t_branch;
    t_other;
    end_of_test;
  end
endmodule // bob_exec_tb

`default_nettype wire
